// >>> core/ext_mem_alu.sv
// module: extended memory alu datapath with banked memory, axi4-lite control
// Operation
// - An op reaches any byte of any memory bank by its full address with no bank select.
// - Add with carry to acc sums acc, memory byte and carry into acc, updating all five flags.
// - Add with carry to memory sums acc, memory byte and carry back into that byte, five flags.
// - Plain add to acc sums acc and memory byte without carry into acc, five flags.
// - Plain add to memory sums acc and memory byte without carry back into that byte.
// - And to acc puts acc and memory byte into acc and changes only the zero flag.
// - And to memory puts acc and memory byte into that byte and changes only the zero flag.
// - Byte clear writes zero to the addressed byte and leaves all flags alone.
// - Bit clear forces the chosen bit of the addressed byte to zero, flags left alone.
//
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
module ext_mem_alu
  import ext_alu_pkg::*;
#(
  parameter int BANKS = 4,
  parameter int BANK_BYTES = 128,
  parameter int AXI_AW = 12
) (
  input wire logic aclk, // core clock
  input wire logic aresetn, // synchronous reset, low active
  input wire logic ce, // clock enable, freezes all state
  input wire logic [AXI_AW-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [AXI_AW-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [7:0] acc_out, // accumulator
  output status_flags_t flags_out // status flags
);

  localparam int MEM_DEPTH = BANKS * BANK_BYTES;
  localparam int MA_W = $clog2(MEM_DEPTH);

  if (BANKS < 1 || BANK_BYTES < 2 || MEM_DEPTH != 2 ** MA_W || MA_W > 16 ||
      AXI_AW < 8) begin : g_bad_params
    $error("ext_mem_alu: memory must be a power of two up to 64k, address >= 8 bits");
  end

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0] acc_r, acc_nxt, cmd_r, cmd_nxt;
  status_flags_t flags_r, flags_nxt;
  logic [MA_W-1:0] addr_r, addr_nxt;
  logic [15:0] count_r, count_nxt;
  logic [7:0] mem_r [MEM_DEPTH];
  logic [7:0] mem_wd, mem_rd;
  logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [AXI_AW-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt, rdata_r, rdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic mem_we, wr_go, rd_go, exec;
  reg_sel_t wsel, rsel;
  logic [31:0] wview, rview, wm;
  ext_op_t cmd_op;
  logic [2:0] cmd_bit;
  alu_out_t alu_res;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic reg_sel_t decode(input logic [AXI_AW-1:0] a);
    reg_sel_t s;
    s = sel_none;
    if (a == AXI_AW'(OFF_CMD)) s = sel_cmd;
    if (a == AXI_AW'(OFF_ADDR)) s = sel_addr;
    if (a == AXI_AW'(OFF_ACC)) s = sel_acc;
    if (a == AXI_AW'(OFF_FLAGS)) s = sel_flags;
    if (a == AXI_AW'(OFF_MEM)) s = sel_mem;
    if (a == AXI_AW'(OFF_COUNT)) s = sel_count;
    return s;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) m[8*i +: 8] = d[8*i +: 8];
    end
    return m;
  endfunction

  function automatic logic [31:0] view(input reg_sel_t s, input logic [7:0] cmd,
                                       input logic [MA_W-1:0] adr, input logic [7:0] acc,
                                       input status_flags_t fl, input logic [7:0] md,
                                       input logic [15:0] cnt);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (s)
      sel_cmd: v = {24'h00_0000, cmd};
      sel_addr: v = 32'(adr);
      sel_acc: v = {24'h00_0000, acc};
      sel_flags: v = {27'h000_0000, fl};
      sel_mem: v = {24'h00_0000, md};
      sel_count: v = {16'h0000, cnt};
      sel_none: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus handshakes; valids are masked while frozen so no beat is lost
  assign awready = ce & ~aw_held_r;
  assign wready = ce & ~w_held_r;
  assign arready = ce & ~rvalid_r;
  assign bvalid = ce & bvalid_r;
  assign rvalid = ce & rvalid_r;
  assign bresp = bresp_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign acc_out = acc_r;
  assign flags_out = flags_r;

  // full address straight into one flat array: no bank select register
  assign mem_rd = mem_r[addr_r];
  assign wr_go = aw_held_r & w_held_r & ~bvalid_r;
  assign rd_go = arvalid & arready;
  assign wsel = decode(awaddr_r);
  assign rsel = decode(araddr);
  assign wview = view(wsel, cmd_r, addr_r, acc_r, flags_r, mem_rd, count_r);
  assign rview = view(rsel, cmd_r, addr_r, acc_r, flags_r, mem_rd, count_r);
  assign wm = merge(wview, wdata_r, wstrb_r);
  // a command runs only when its low byte is written
  assign exec = wr_go & (wsel == sel_cmd) & wstrb_r[0];
  assign cmd_op = ext_op_t'(wdata_r[CMD_OP_LSB +: 3]);
  assign cmd_bit = wdata_r[CMD_BIT_LSB +: 3];

  ext_alu_unit u_alu (
    .op(cmd_op),
    .acc(acc_r),
    .mem(mem_rd),
    .bit_sel(cmd_bit),
    .flags_in(flags_r),
    .res(alu_res)
  );

  ////////////////////////////////////////////////////////////////////////////
  // axi channel state
  always_comb begin
    aw_held_nxt = aw_held_r;
    awaddr_nxt = awaddr_r;
    w_held_nxt = w_held_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r & ~bready;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r & ~rready;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (awvalid && awready) begin
      aw_held_nxt = 1'b1;
      awaddr_nxt = awaddr;
    end
    if (wvalid && wready) begin
      w_held_nxt = 1'b1;
      wdata_nxt = wdata;
      wstrb_nxt = wstrb;
    end
    if (wr_go) begin
      aw_held_nxt = 1'b0;
      w_held_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (wsel == sel_none) ? RESP_SLVERR : RESP_OKAY;
    end
    if (rd_go) begin
      rvalid_nxt = 1'b1;
      rdata_nxt = rview;
      rresp_nxt = (rsel == sel_none) ? RESP_SLVERR : RESP_OKAY;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else if (ce) begin
      aw_held_r <= aw_held_nxt;
      awaddr_r <= awaddr_nxt;
      w_held_r <= w_held_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // datapath state
  always_comb begin
    acc_nxt = acc_r;
    flags_nxt = flags_r;
    addr_nxt = addr_r;
    cmd_nxt = cmd_r;
    count_nxt = count_r;
    mem_we = 1'b0;
    mem_wd = mem_rd;
    if (exec) begin
      // flags come back untouched from the unit for clear ops
      flags_nxt = alu_res.flags;
      if (alu_res.to_acc) acc_nxt = alu_res.value;
      mem_we = alu_res.to_mem;
      mem_wd = alu_res.value;
      cmd_nxt = wdata_r[7:0];
      count_nxt = count_r + 16'h0001;
    end else if (wr_go) begin
      unique case (wsel)
        sel_addr: addr_nxt = wm[MA_W-1:0];
        sel_acc: acc_nxt = wm[7:0];
        sel_flags: flags_nxt = status_flags_t'(wm[4:0]);
        sel_mem: begin
          mem_we = 1'b1;
          mem_wd = wm[7:0];
        end
        sel_cmd, sel_count, sel_none: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_r <= ACC_RST;
      flags_r <= FLAGS_RST;
      addr_r <= '0;
      cmd_r <= CMD_RST;
      count_r <= COUNT_RST;
    end else if (ce) begin
      acc_r <= acc_nxt;
      flags_r <= flags_nxt;
      addr_r <= addr_nxt;
      cmd_r <= cmd_nxt;
      count_r <= count_nxt;
    end
  end

  // storage is not reset; software clears what it needs
  always_ff @(posedge aclk) begin
    if (ce && mem_we) mem_r[addr_r] <= mem_wd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks against an independent reference
  logic [8:0] ref_c, ref_n;
  logic [7:0] and_ref, bit_mask;
  logic [3:0] nz_flags;
  assign ref_c = {1'b0, acc_r} + {1'b0, mem_rd} + {8'h00, flags_r.carry};
  assign ref_n = {1'b0, acc_r} + {1'b0, mem_rd};
  assign and_ref = acc_r & mem_rd;
  assign bit_mask = 8'h01 << cmd_bit;
  assign nz_flags = {flags_r.signed_compare_flag, flags_r.signed_wrap_flag,
                     flags_r.nibble_carry_flag, flags_r.carry};

  property p_any_bank;
    @(posedge aclk) disable iff (!aresetn)
    exec && alu_res.to_mem |=> mem_rd == $past(mem_wd) && addr_r == $past(addr_r);
  endproperty
  a_any_bank: assert property (p_any_bank) else $error("memory write missed address");
  property p_adc_acc;
    @(posedge aclk) disable iff (!aresetn)
    exec && cmd_op == op_add_mem_to_acc_with_carry |=>
      acc_r == 8'($past(ref_c)) && flags_r.carry == $past(ref_c[8]);
  endproperty
  a_adc_acc: assert property (p_adc_acc) else $error("add with carry to acc wrong");
  property p_adc_mem;
    @(posedge aclk) disable iff (!aresetn)
    exec && cmd_op == op_add_acc_carry_into_mem |=>
      mem_rd == 8'($past(ref_c)) && acc_r == $past(acc_r);
  endproperty
  a_adc_mem: assert property (p_adc_mem) else $error("add with carry to mem wrong");
  property p_add_acc;
    @(posedge aclk) disable iff (!aresetn)
    exec && cmd_op == op_add_mem_to_acc |=>
      acc_r == 8'($past(ref_n)) && flags_r.zero == (8'($past(ref_n)) == 8'h00);
  endproperty
  a_add_acc: assert property (p_add_acc) else $error("add to acc wrong");
  property p_add_mem;
    @(posedge aclk) disable iff (!aresetn)
    exec && cmd_op == op_add_acc_into_mem |=>
      mem_rd == 8'($past(ref_n)) && flags_r.carry == $past(ref_n[8]);
  endproperty
  a_add_mem: assert property (p_add_mem) else $error("add to mem wrong");
  property p_and_acc;
    @(posedge aclk) disable iff (!aresetn)
    exec && cmd_op == op_and_mem_to_acc |=>
      acc_r == $past(and_ref) && nz_flags == $past(nz_flags);
  endproperty
  a_and_acc: assert property (p_and_acc) else $error("and to acc wrong");
  property p_and_mem;
    @(posedge aclk) disable iff (!aresetn)
    exec && cmd_op == op_and_acc_into_mem |=> mem_rd == $past(and_ref) &&
      flags_r.zero == ($past(and_ref) == 8'h00) && nz_flags == $past(nz_flags);
  endproperty
  a_and_mem: assert property (p_and_mem) else $error("and to mem wrong");
  property p_clr_byte;
    @(posedge aclk) disable iff (!aresetn)
    exec && cmd_op == op_clear_mem_byte_or_bit_all |=>
      mem_rd == CLEAR_BYTE && flags_r == $past(flags_r);
  endproperty
  a_clr_byte: assert property (p_clr_byte) else $error("byte clear wrong");
  property p_clr_bit;
    @(posedge aclk) disable iff (!aresetn)
    exec && cmd_op == op_clear_mem_byte_or_bit_one |=>
      (mem_rd & $past(bit_mask)) == 8'h00 && flags_r == $past(flags_r);
  endproperty
  a_clr_bit: assert property (p_clr_bit) else $error("bit clear wrong");
  property p_clr_bit_keep;
    @(posedge aclk) disable iff (!aresetn)
    exec && cmd_op == op_clear_mem_byte_or_bit_one |=>
      (mem_rd | $past(bit_mask)) == ($past(mem_rd) | $past(bit_mask));
  endproperty
  a_clr_bit_keep: assert property (p_clr_bit_keep) else $error("bit clear hit others");

endmodule

// >>> core/ext_alu_pkg.sv
// package: constants and types for the extended memory alu datapath
package ext_alu_pkg;

  localparam int DATA_W = 8;

  // register byte offsets on the control bus
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_ACC = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0C;
  localparam logic [7:0] OFF_MEM = 8'h10;
  localparam logic [7:0] OFF_COUNT = 8'h14;

  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_BIT_LSB = 4;

  // reset values, and the value byte clear writes
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h00;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [7:0] CLEAR_BYTE = 8'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    op_add_mem_to_acc_with_carry = 3'h0,
    op_add_acc_carry_into_mem = 3'h1,
    op_add_mem_to_acc = 3'h2,
    op_add_acc_into_mem = 3'h3,
    op_and_mem_to_acc = 3'h4,
    op_and_acc_into_mem = 3'h5,
    op_clear_mem_byte_or_bit_all = 3'h6,
    op_clear_mem_byte_or_bit_one = 3'h7
  } ext_op_t;

  // flags register: bit0 carry .. bit4 signed compare
  typedef struct packed {
    logic signed_compare_flag;
    logic signed_wrap_flag;
    logic zero;
    logic nibble_carry_flag;
    logic carry;
  } status_flags_t;

  typedef struct packed {
    logic [DATA_W-1:0] value;
    status_flags_t flags;
    logic to_acc;
    logic to_mem;
  } alu_out_t;

  typedef enum logic [2:0] {
    sel_cmd = 3'h0,
    sel_addr = 3'h1,
    sel_acc = 3'h2,
    sel_flags = 3'h3,
    sel_mem = 3'h4,
    sel_count = 3'h5,
    sel_none = 3'h6
  } reg_sel_t;

endpackage

// >>> core/ext_alu_unit.sv
// module: combinational result and flag logic of the extended ops
module ext_alu_unit
  import ext_alu_pkg::*;
(
  input wire ext_op_t op, // op being executed
  input wire logic [7:0] acc, // accumulator operand
  input wire logic [7:0] mem, // addressed memory byte
  input wire logic [2:0] bit_sel, // bit position for bit clear
  input wire status_flags_t flags_in, // current flags
  output alu_out_t res // result, new flags, destination
);

  logic cin;
  logic [8:0] sum;
  logic [4:0] low;
  logic [7:0] andv;

  always_comb begin
    cin = (op == op_add_mem_to_acc_with_carry || op == op_add_acc_carry_into_mem) ?
          flags_in.carry : 1'b0;
    sum = {1'b0, acc} + {1'b0, mem} + {8'h00, cin};
    low = {1'b0, acc[3:0]} + {1'b0, mem[3:0]} + {4'h0, cin};
    andv = acc & mem;
    res.value = mem;
    res.flags = flags_in;
    res.to_acc = 1'b0;
    res.to_mem = 1'b0;
    unique case (op)
      op_add_mem_to_acc_with_carry, op_add_acc_carry_into_mem,
      op_add_mem_to_acc, op_add_acc_into_mem: begin
        res.value = sum[7:0];
        res.flags.carry = sum[8];
        res.flags.nibble_carry_flag = low[4];
        res.flags.zero = (sum[7:0] == 8'h00);
        // overflow: like-signed operands giving an other-signed sum
        res.flags.signed_wrap_flag = (acc[7] == mem[7]) && (sum[7] != acc[7]);
        res.flags.signed_compare_flag = res.flags.signed_wrap_flag ^ sum[7];
        res.to_acc = (op == op_add_mem_to_acc_with_carry) || (op == op_add_mem_to_acc);
        res.to_mem = !res.to_acc;
      end
      op_and_mem_to_acc, op_and_acc_into_mem: begin
        res.value = andv;
        res.flags.zero = (andv == 8'h00);
        res.to_acc = (op == op_and_mem_to_acc);
        res.to_mem = (op == op_and_acc_into_mem);
      end
      op_clear_mem_byte_or_bit_all: begin
        res.value = CLEAR_BYTE;
        res.to_mem = 1'b1;
      end
      op_clear_mem_byte_or_bit_one: begin
        res.value = mem & ~(8'h01 << bit_sel);
        res.to_mem = 1'b1;
      end
    endcase
  end

endmodule

// >>> bench/ext_mem_alu_test.sv
// testbench: extended memory alu datapath driven over its axi4-lite control port
module ext_mem_alu_test
  import ext_alu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic aclk;
  logic aresetn;
  logic ce;
  logic [11:0] awaddr;
  logic [11:0] araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [7:0] acc_out;
  status_flags_t flags_out;
  int mismatches = 0;
  int samples_checked = 0;
  logic [31:0] rd;
  logic [1:0] rsp;
  // operand cases: signed wrap with carry in, carry out to zero, and to zero, mixed
  logic [7:0] ca [4] = '{8'h7F, 8'hFF, 8'h0F, 8'hA5};
  logic [7:0] cm [4] = '{8'h01, 8'h01, 8'hF0, 8'hC3};
  logic [4:0] cf [4] = '{5'h01, 5'h00, 5'h1F, 5'h0A};
  logic [8:0] cad [4] = '{9'h003, 9'h0FF, 9'h17E, 9'h1FF};

  ext_mem_alu uut (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .acc_out(acc_out), .flags_out(flags_out)
  );

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    mismatches++;
    $display("MISMATCH %s expected handshake seen timeout", what);
    results;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] ex);
    samples_checked++;
    if (seen !== ex) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, ex, seen);
    end
  endtask

  // entered and left just after a rising edge; ready sampled at the negedge before the edge
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    logic aw_ok, w_ok, aw_hit, w_hit, b_hit;
    int n;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    b_hit = 1'b0;
    n = 0;
    awaddr <= {4'h0, a};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge aclk);
      aw_hit = awready && !aw_ok;
      w_hit = wready && !w_ok;
      @(posedge aclk);
      if (aw_hit) begin
        awvalid <= 1'b0;
        aw_ok = 1'b1;
      end
      if (w_hit) begin
        wvalid <= 1'b0;
        w_ok = 1'b1;
      end
      n++;
      if (n > 50) hang("write request");
    end
    while (!b_hit) begin
      @(negedge aclk);
      b_hit = bvalid;
      rsp = bresp;
      @(posedge aclk);
      n++;
      if (n > 100) hang("write response");
    end
    check("bresp", {30'h0, rsp}, {30'h0, er});
  endtask

  task automatic axi_read(input string what, input logic [7:0] a, input logic [31:0] ex,
                          input logic [1:0] er);
    logic hit;
    int n;
    hit = 1'b0;
    n = 0;
    araddr <= {4'h0, a};
    arvalid <= 1'b1;
    while (!hit) begin
      @(negedge aclk);
      hit = arready;
      @(posedge aclk);
      n++;
      if (n > 50) hang(what);
    end
    arvalid <= 1'b0;
    hit = 1'b0;
    while (!hit) begin
      @(negedge aclk);
      hit = rvalid;
      rd = rdata;
      rsp = rresp;
      @(posedge aclk);
      n++;
      if (n > 100) hang(what);
    end
    check(what, rd, ex);
    check({what, " rresp"}, {30'h0, rsp}, {30'h0, er});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // expected {acc, mem, flags} after one op
  function automatic logic [20:0] model(input logic [2:0] op, input logic [7:0] a,
                                        input logic [7:0] m, input logic [2:0] bi,
                                        input logic [4:0] f);
    logic cin, wrap;
    logic [8:0] s;
    logic [4:0] nib;
    logic [7:0] r, na, nm;
    logic [4:0] nf;
    cin = (op < 3'h2) ? f[0] : 1'b0;
    s = {1'b0, a} + {1'b0, m} + {8'h00, cin};
    nib = {1'b0, a[3:0]} + {1'b0, m[3:0]} + {4'h0, cin};
    r = s[7:0];
    wrap = (a[7] == m[7]) && (r[7] != a[7]);
    na = a;
    nm = m;
    nf = f;
    if (op < 3'h4) nf = {wrap ^ r[7], wrap, r == 8'h00, nib[4], s[8]};
    if (op == 3'h4 || op == 3'h5) nf[2] = (a & m) == 8'h00;
    case (op)
      3'h0, 3'h2: na = r;
      3'h1, 3'h3: nm = r;
      3'h4: na = a & m;
      3'h5: nm = a & m;
      3'h6: nm = 8'h00;
      default: nm[bi] = 1'b0;
    endcase
    return {na, nm, nf};
  endfunction

  task automatic run_op(input logic [2:0] op, input logic [7:0] a, input logic [7:0] m,
                        input logic [4:0] f, input logic [8:0] ad, input logic [2:0] bi);
    logic [20:0] e;
    e = model(op, a, m, bi, f);
    // same offset in the neighbouring bank must stay untouched
    axi_write(OFF_ADDR, {23'h0, ad ^ 9'h080}, 4'hF, RESP_OKAY);
    axi_write(OFF_MEM, 32'h0000_005A, 4'hF, RESP_OKAY);
    axi_write(OFF_ADDR, {23'h0, ad}, 4'hF, RESP_OKAY);
    axi_write(OFF_MEM, {24'h0, m}, 4'hF, RESP_OKAY);
    axi_write(OFF_ACC, {24'h0, a}, 4'hF, RESP_OKAY);
    axi_write(OFF_FLAGS, {27'h0, f}, 4'hF, RESP_OKAY);
    axi_write(OFF_CMD, {25'h0, bi, 1'b0, op}, 4'hF, RESP_OKAY);
    check("acc port", {24'h0, acc_out}, {24'h0, e[20:13]});
    check("flags port", {27'h0, flags_out}, {27'h0, e[4:0]});
    axi_read("acc", OFF_ACC, {24'h0, e[20:13]}, RESP_OKAY);
    axi_read("flags", OFF_FLAGS, {27'h0, e[4:0]}, RESP_OKAY);
    axi_read("mem", OFF_MEM, {24'h0, e[12:5]}, RESP_OKAY);
    axi_write(OFF_ADDR, {23'h0, ad ^ 9'h080}, 4'hF, RESP_OKAY);
    axi_read("other bank", OFF_MEM, 32'h0000_005A, RESP_OKAY);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aresetn = 1'b0;
    ce = 1'b1;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    // response readies stay high all run: back-to-back calls never re-drive them
    bready = 1'b1;
    arvalid = 1'b0;
    rready = 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    axi_read("cmd", OFF_CMD, {24'h0, CMD_RST}, RESP_OKAY);
    axi_read("addr", OFF_ADDR, 32'h0, RESP_OKAY);
    axi_read("acc", OFF_ACC, {24'h0, ACC_RST}, RESP_OKAY);
    axi_read("flags", OFF_FLAGS, {27'h0, FLAGS_RST}, RESP_OKAY);
    axi_read("count", OFF_COUNT, {16'h0, COUNT_RST}, RESP_OKAY);
    axi_read("unmapped", 8'h18, 32'h0, RESP_SLVERR);
    axi_write(8'h18, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
    axi_write(OFF_COUNT, 32'h0000_1234, 4'hF, RESP_OKAY);
    axi_read("count", OFF_COUNT, 32'h0, RESP_OKAY);
    $display("test reset and map done");
    for (int c = 0; c < 4; c++) begin
      for (int op = 0; op < 8; op++) begin
        run_op(3'(op), ca[c], cm[c], cf[c], cad[c], 3'(2 * c + 1));
      end
    end
    $display("test ops done");
    // a command write without its low byte strobe runs nothing
    axi_write(OFF_CMD, 32'h0000_0002, 4'hE, RESP_OKAY);
    axi_read("count", OFF_COUNT, 32'h0000_0020, RESP_OKAY);
    // last run was bit clear of bit 7, code 7; the unstrobed write kept it
    axi_read("cmd", OFF_CMD, 32'h0000_0077, RESP_OKAY);
    $display("test op count done");
    // a frozen block takes no request and answers none
    ce <= 1'b0;
    araddr <= {4'h0, OFF_ACC};
    arvalid <= 1'b1;
    repeat (3) @(posedge aclk);
    check("frozen handshake", {28'h0, awready, wready, arready, rvalid}, 32'h0000_0000);
    ce <= 1'b1;
    axi_read("acc after freeze", OFF_ACC, {24'h0, ca[3]}, RESP_OKAY);
    $display("test freeze done");
    results;
  end
endmodule
